/* File: core/psg_top.sv */
// Power save, wake-up sequencing, status register and peripheral gating.
// Assumes synchronous CPU strobes on clk and asynchronous pins/analog flags.
`timescale 1ns/10ps
`default_nettype none
module psg_top #(
  parameter int          NUM_PERIPH      = 32,
  parameter int          POWERON_CYC     = psg_pkg::POWERON_DELAY_CYC,
  parameter int          SETTLE_CYC      = psg_pkg::SETTLE_DELAY_CYC,
  parameter logic [23:0] CFG_OSC_VAL     = 24'h00C100,
  parameter logic [23:0] CFG_WDT_VAL     = 24'h00803F,
  parameter logic [23:0] CFG_BOR_VAL     = 24'h0087B3,
  parameter logic [23:0] CFG_BOOT_VAL    = 24'h00310F,
  parameter logic [23:0] CFG_SEC_VAL     = 24'h00330F,
  parameter logic [23:0] CFG_GEN_VAL     = 24'h000007,
  parameter logic [NUM_PERIPH-1:0] PRESENT = '1
) (
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire logic                  por_event,
  input  wire logic                  bor_event,
  input  wire logic                  ext_reset_event,
  input  wire logic                  pwrsave_retire,
  input  wire logic                  pwrsave_operand,
  input  wire logic                  irq_wake_req,
  input  wire logic                  wdt_timeout,
  input  wire logic                  wdt_enabled,
  input  wire logic                  clock_switch_en,
  input  wire logic [2:0]            current_oscillator_select,
  input  wire logic                  clock_fail_monitor_en,
  input  wire logic                  brownout_en,
  input  wire logic                  ost_done,
  input  wire logic                  pll_lock,
  input  wire logic                  osc_running,
  input  wire logic                  reference_ready,
  input  wire logic                  status_we,
  input  wire logic [15:0]           status_wdata,
  input  wire logic                  cfg_re,
  input  wire logic [23:0]           cfg_addr,
  input  wire logic [NUM_PERIPH-1:0] peripheral_clock_gate,
  output var  logic [15:0]           status_r,
  output var  logic [23:0]           cfg_rdata_r,
  output var  logic                  cpu_clk_en_r,
  output var  logic                  periph_clk_en_r,
  output var  logic                  osc_en_r,
  output var  logic                  slow_rc_en_r,
  output var  logic                  monitor_active_r,
  output var  logic                  brownout_active_r,
  output var  logic                  supply_detect_run_r,
  output var  logic [3:0]            supply_trip_level_r,
  output var  logic                  irq_vector_r,
  output var  logic                  clock_fail_trap_r,
  output var  logic                  fast_rc_force_r,
  output var  logic [2:0]            wake_osc_r,
  output var  logic [NUM_PERIPH-1:0] periph_run_r
);
  typedef enum logic [2:0] {
    PSG_RUN, PSG_SLEEP, PSG_IDLE, PSG_WAKE_DLY, PSG_WAKE_CLK, PSG_STALL
  } psg_state_e;

  localparam int CW = $clog2(SETTLE_CYC + POWERON_CYC + 2);

  // Two-flop synchronisers for asynchronous inputs
  logic [6:0] sync1_r;
  logic [6:0] sync2_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_r <= 7'h00;
      sync2_r <= 7'h00;
    end else begin
      sync1_r <= {por_event, bor_event, ext_reset_event, ost_done, pll_lock,
                  osc_running, reference_ready};
      sync2_r <= sync1_r;
    end
  end
  logic por_s, bor_s, ext_s, ost_s, lock_s, run_s, ref_s;
  assign {por_s, bor_s, ext_s, ost_s, lock_s, run_s, ref_s} = sync2_r;

  psg_pkg::psg_wake_s wake;
  assign wake.irq   = irq_wake_req;
  assign wake.reset = por_s | bor_s | ext_s;
  assign wake.wdt   = wdt_timeout & wdt_enabled;

  psg_state_e state_r;
  psg_pkg::psg_mode_e left_mode_r;
  logic [CW-1:0] dly_r;
  logic          lp_kept_r;
  logic          pll_mode;
  logic          xtal_mode;
  logic          fast_osc;
  assign pll_mode  = wake_osc_r == psg_pkg::OSC_PLL;
  assign xtal_mode = wake_osc_r == psg_pkg::OSC_CRYSTAL || pll_mode;
  assign fast_osc  = !xtal_mode && !(wake_osc_r == psg_pkg::OSC_LP_XTAL && !lp_kept_r);

  // Wake clock selection
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_osc_r <= psg_pkg::OSC_FAST_RC;
    end else if (por_s || bor_s) begin
      wake_osc_r <= CFG_OSC_VAL[10:8];
    end else if (pwrsave_retire && clock_switch_en) begin
      wake_osc_r <= current_oscillator_select;
    end
  end

  // Power state sequencer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= PSG_RUN;
      left_mode_r <= psg_pkg::PSG_MODE_SLEEP;
      dly_r <= '0;
      lp_kept_r <= 1'b0;
    end else begin
      unique case (state_r)
        PSG_RUN: begin
          if (pwrsave_retire) begin
            if (pwrsave_operand) begin
              state_r <= PSG_IDLE;
              left_mode_r <= psg_pkg::PSG_MODE_IDLE;
            end else begin
              state_r <= PSG_SLEEP;
              left_mode_r <= psg_pkg::PSG_MODE_SLEEP;
              lp_kept_r <= psg_pkg::OSC_LP_XTAL ==
                           (clock_switch_en ? current_oscillator_select : wake_osc_r);
            end
          end
        end
        PSG_SLEEP: begin
          if (wake.irq || wake.reset || wake.wdt) begin
            state_r <= PSG_WAKE_DLY;
            dly_r <= fast_osc ? CW'(POWERON_CYC)
                              : CW'(POWERON_CYC + SETTLE_CYC);
          end
        end
        PSG_IDLE: begin
          if (wake.irq || wake.reset || wake.wdt) begin
            state_r <= PSG_RUN;
          end
        end
        PSG_WAKE_DLY: begin
          if (dly_r <= CW'(1)) begin
            state_r <= fast_osc ? PSG_RUN : PSG_WAKE_CLK;
          end
          dly_r <= dly_r - CW'(1);
        end
        PSG_WAKE_CLK: begin
          if (run_s && (pll_mode ? lock_s : ost_s)) begin
            state_r <= PSG_RUN;
          end else if (clock_fail_monitor_en) begin
            state_r <= PSG_RUN;
          end else begin
            state_r <= PSG_STALL;
          end
        end
        PSG_STALL: begin
          if (run_s && (pll_mode ? lock_s : ost_s)) begin
            state_r <= PSG_RUN;
          end
        end
        default: state_r <= PSG_RUN;
      endcase
    end
  end

  // Clock enables, changed only on clock edges so gated clocks see whole pulses
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_clk_en_r <= 1'b1;
      periph_clk_en_r <= 1'b1;
      osc_en_r <= 1'b1;
      slow_rc_en_r <= 1'b0;
      monitor_active_r <= 1'b0;
      brownout_active_r <= 1'b0;
    end else begin
      cpu_clk_en_r <= state_r == PSG_RUN && !pwrsave_retire;
      periph_clk_en_r <= !(state_r inside {PSG_SLEEP, PSG_WAKE_DLY, PSG_WAKE_CLK,
                           PSG_STALL}) && !(pwrsave_retire && !pwrsave_operand);
      osc_en_r <= state_r != PSG_SLEEP || lp_kept_r;
      slow_rc_en_r <= wdt_enabled || (clock_fail_monitor_en && state_r != PSG_SLEEP);
      monitor_active_r <= clock_fail_monitor_en && state_r != PSG_SLEEP;
      brownout_active_r <= brownout_en;
    end
  end

  // Trap and handler branch pulses; fast RC force held from a trap until the next pwrsave_retire
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clock_fail_trap_r <= 1'b0;
      fast_rc_force_r <= 1'b0;
      irq_vector_r <= 1'b0;
    end else begin
      clock_fail_trap_r <= state_r == PSG_WAKE_CLK && clock_fail_monitor_en &&
                           !(run_s && (pll_mode ? lock_s : ost_s));
      if (clock_fail_trap_r) begin
        fast_rc_force_r <= 1'b1;
      end else if (pwrsave_retire) begin
        fast_rc_force_r <= 1'b0;
      end
      irq_vector_r <= wake.irq && (state_r == PSG_IDLE || state_r == PSG_SLEEP);
    end
  end

  // Status register
  logic in_sleep, in_idle, settle_done_r;
  logic [CW-1:0] settle_cnt_r;
  assign in_sleep = state_r == PSG_SLEEP;
  assign in_idle  = state_r == PSG_IDLE;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_r <= 16'h0003;
    end else begin
      if (status_we) begin
        status_r <= (status_wdata & psg_pkg::STATUS_WR_MASK) |
                    (status_r & ~psg_pkg::STATUS_WR_MASK);
      end
      status_r[psg_pkg::POS_SETTLED] <= status_r[psg_pkg::POS_DET_EN] && settle_done_r;
      if (por_s) begin
        status_r[psg_pkg::POS_POR]   <= 1'b1;
        status_r[psg_pkg::POS_BOR]   <= 1'b1;
        status_r[psg_pkg::POS_SLEEP] <= 1'b0;
        status_r[psg_pkg::POS_IDLE]  <= 1'b0;
      end else begin
        if (bor_s) begin
          status_r[psg_pkg::POS_BOR] <= 1'b1;
        end
        if ((bor_s || ext_s || wake.irq || wake.wdt) && in_sleep) begin
          status_r[psg_pkg::POS_SLEEP] <= 1'b1;
        end
        if ((bor_s || ext_s || wake.irq || wake.wdt) && in_idle) begin
          status_r[psg_pkg::POS_IDLE] <= 1'b1;
        end
        if (wake.wdt && (in_sleep || in_idle)) begin
          status_r[psg_pkg::POS_WATCHDOG_TIMEOUT_FLAG] <= 1'b1;
        end
      end
    end
  end

  // Reference settle timer restarts whenever the detector is turned off
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      settle_cnt_r <= '0;
      settle_done_r <= 1'b0;
    end else if (!status_r[psg_pkg::POS_DET_EN]) begin
      settle_cnt_r <= '0;
      settle_done_r <= 1'b0;
    end else if (settle_cnt_r >= CW'(SETTLE_CYC - 1)) begin
      settle_done_r <= ref_s;
    end else begin
      settle_cnt_r <= settle_cnt_r + CW'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      supply_detect_run_r <= 1'b0;
      supply_trip_level_r <= 4'h0;
    end else begin
      supply_detect_run_r <= status_r[psg_pkg::POS_DET_EN];
      supply_trip_level_r <= status_r[psg_pkg::POS_TRIP_HI:psg_pkg::POS_TRIP_LO];
    end
  end

  // Configuration words: read only, upper byte zero
  logic [23:0] cfg_word;
  always_comb begin
    unique case (cfg_addr)
      psg_pkg::ADDR_CFG_OSC:  cfg_word = CFG_OSC_VAL;
      psg_pkg::ADDR_CFG_WDT:  cfg_word = CFG_WDT_VAL;
      psg_pkg::ADDR_CFG_BOR:  cfg_word = CFG_BOR_VAL;
      psg_pkg::ADDR_CFG_BOOT: cfg_word = CFG_BOOT_VAL;
      psg_pkg::ADDR_CFG_SEC:  cfg_word = CFG_SEC_VAL;
      psg_pkg::ADDR_CFG_GEN:  cfg_word = CFG_GEN_VAL;
      default:                cfg_word = 24'h000000;
    endcase
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_rdata_r <= 24'h000000;
    end else if (cfg_re) begin
      cfg_rdata_r <= {8'h00, cfg_word[psg_pkg::CFG_USED_BITS-1:0]};
    end
  end

  // Per-peripheral gates; run_r low means clocks stopped and registers frozen
  for (genvar i = 0; i < NUM_PERIPH; i++) begin : g_gate
    psg_gate_bit u_gate (
      .clk         (clk),
      .rst_b       (rst_b),
      .disable_bit (peripheral_clock_gate[i]),
      .present     (PRESENT[i]),
      .run_r       (periph_run_r[i])
    );
  end

  // Assertions
  sleep_entry_a: assert property (@(posedge clk) disable iff (!rst_b)
    state_r == PSG_RUN && pwrsave_retire && !pwrsave_operand |=> state_r == PSG_SLEEP)
    else $error("sleep not entered");
  idle_entry_a: assert property (@(posedge clk) disable iff (!rst_b)
    state_r == PSG_RUN && pwrsave_retire && pwrsave_operand |=> state_r == PSG_IDLE)
    else $error("idle not entered");
  sleep_clocks_a: assert property (@(posedge clk) disable iff (!rst_b)
    state_r == PSG_SLEEP |=> !cpu_clk_en_r && !periph_clk_en_r) else $error("clock in sleep");
  idle_periph_a: assert property (@(posedge clk) disable iff (!rst_b)
    state_r == PSG_IDLE |=> !cpu_clk_en_r && periph_clk_en_r && osc_en_r)
    else $error("idle gating wrong");
  idle_wake_a: assert property (@(posedge clk) disable iff (!rst_b)
    state_r == PSG_IDLE && wake.irq |=> state_r == PSG_RUN ##1 cpu_clk_en_r)
    else $error("idle wake slow");
  sleep_wake_a: assert property (@(posedge clk) disable iff (!rst_b)
    state_r == PSG_SLEEP && (wake.irq || wake.wdt) |=> state_r == PSG_WAKE_DLY)
    else $error("sleep wake missed");
  watchdog_timeout_flag_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
    state_r == PSG_SLEEP && wake.wdt && !por_s |=> status_r[psg_pkg::POS_WATCHDOG_TIMEOUT_FLAG]
      && status_r[psg_pkg::POS_SLEEP]) else $error("wdt flags not set");
  por_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    por_s |=> !status_r[psg_pkg::POS_SLEEP] && !status_r[psg_pkg::POS_IDLE])
    else $error("por did not clear");
  gate_lat_a: assert property (@(posedge clk) disable iff (!rst_b)
    peripheral_clock_gate[0] |=> !periph_run_r[0]) else $error("gate late");
  trap_a: assert property (@(posedge clk) disable iff (!rst_b)
    state_r == PSG_WAKE_CLK && clock_fail_monitor_en && !run_s |=> clock_fail_trap_r
      ##1 fast_rc_force_r) else $error("trap missing");
  detect_a: assert property (@(posedge clk) disable iff (!rst_b)
    supply_detect_run_r == $past(status_r[psg_pkg::POS_DET_EN])) else $error("detect off");
  cfg_hi_a: assert property (@(posedge clk) disable iff (!rst_b)
    cfg_re && cfg_addr == psg_pkg::ADDR_CFG_OSC |=> cfg_rdata_r == {8'h00, CFG_OSC_VAL[15:0]})
    else $error("config word wrong");
  c_sleep_c: cover property (@(posedge clk) disable iff (!rst_b)
    state_r == PSG_SLEEP ##1 state_r == PSG_WAKE_DLY);
  c_idle_c: cover property (@(posedge clk) disable iff (!rst_b)
    state_r == PSG_IDLE ##1 state_r == PSG_RUN);
  c_stall_c: cover property (@(posedge clk) disable iff (!rst_b) state_r == PSG_STALL);
endmodule
`default_nettype wire

/* File: core/psg_pkg.sv */
// Package for the power save and module gating block.
// Assumes a single 250 MHz clock domain; instruction cycle equals one clock.
`default_nettype none
package psg_pkg;
  // Status register field positions
  localparam int POS_POR      = 0;
  localparam int POS_BOR      = 1;
  localparam int POS_IDLE     = 2;
  localparam int POS_SLEEP    = 3;
  localparam int POS_WATCHDOG_TIMEOUT_FLAG     = 4;
  localparam int POS_SWDTEN   = 5;
  localparam int POS_TRIP_LO  = 8;
  localparam int POS_TRIP_HI  = 11;
  localparam int POS_DET_EN   = 12;
  localparam int POS_SETTLED  = 13;
  localparam logic [15:0] STATUS_WR_MASK = 16'h1F3F;

  // Configuration word addresses
  localparam logic [23:0] ADDR_CFG_OSC  = 24'hF80000;
  localparam logic [23:0] ADDR_CFG_WDT  = 24'hF80002;
  localparam logic [23:0] ADDR_CFG_BOR  = 24'hF80004;
  localparam logic [23:0] ADDR_CFG_BOOT = 24'hF80006;
  localparam logic [23:0] ADDR_CFG_SEC  = 24'hF80008;
  localparam logic [23:0] ADDR_CFG_GEN  = 24'hF8000A;
  localparam int CFG_WORDS = 6;
  localparam int CFG_USED_BITS = 16;

  // Oscillator selector codes for the current oscillator field
  localparam logic [2:0] OSC_EXT_CLOCK = 3'h0;
  localparam logic [2:0] OSC_FAST_RC   = 3'h1;
  localparam logic [2:0] OSC_SLOW_RC   = 3'h2;
  localparam logic [2:0] OSC_EXT_RC    = 3'h3;
  localparam logic [2:0] OSC_CRYSTAL   = 3'h4;
  localparam logic [2:0] OSC_LP_XTAL   = 3'h5;
  localparam logic [2:0] OSC_PLL       = 3'h6;

  // Timing
  localparam int CLK_MHZ = 250;
  localparam int POWERON_DELAY_US = 10;
  localparam int POWERON_DELAY_CYC = POWERON_DELAY_US * CLK_MHZ;
  localparam int SETTLE_DELAY_US = 20;
  localparam int SETTLE_DELAY_CYC = SETTLE_DELAY_US * CLK_MHZ;
  localparam int PERIPH_GATE_LAT = 1;

  typedef enum logic { PSG_MODE_SLEEP, PSG_MODE_IDLE } psg_mode_e;

  typedef struct packed {
    logic irq;
    logic reset;
    logic wdt;
  } psg_wake_s;

  typedef struct packed {
    logic        we;
    logic        re;
    logic [15:0] wdata;
  } psg_reg_req_s;
endpackage
`default_nettype wire

/* File: core/psg_gate_bit.sv */
// One peripheral clock gate with one instruction cycle of latency.
// Assumes clk is the instruction clock and the disable bit is synchronous.
`timescale 1ns/10ps
`default_nettype none
module psg_gate_bit (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic disable_bit,
  input  wire logic present,
  output var  logic run_r
);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_r <= 1'b0;
    end else begin
      run_r <= present & ~disable_bit;
    end
  end
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench for the power save, wake-up and peripheral gating block.
// Assumes psg_pkg and psg_top are compiled first; the bench drives every input.
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int          PON  = 8;
  localparam int          SET  = 8;
  localparam logic [31:0] PRES = 32'h7FFFFFFF;
  logic        clk, rst_b, por_event, bor_event, ext_reset_event, pwrsave_retire;
  logic        pwrsave_operand, irq_wake_req, wdt_timeout, wdt_enabled, clock_switch_en;
  logic        clock_fail_monitor_en, brownout_en, ost_done, pll_lock, osc_running;
  logic        reference_ready, status_we, cfg_re;
  logic [2:0]  current_oscillator_select, wake_osc_r;
  logic [15:0] status_wdata, status_r;
  logic [23:0] cfg_addr, cfg_rdata_r;
  logic [31:0] peripheral_clock_gate, periph_run_r;
  logic        cpu_clk_en_r, periph_clk_en_r, osc_en_r, slow_rc_en_r, monitor_active_r;
  logic        brownout_active_r, supply_detect_run_r, irq_vector_r, clock_fail_trap_r;
  logic        fast_rc_force_r;
  logic [3:0]  supply_trip_level_r;
  int          err_total;
  int          checked;
  logic [23:0] cfg_exp [6];

  psg_top #(.NUM_PERIPH(32), .POWERON_CYC(PON), .SETTLE_CYC(SET), .PRESENT(PRES)) DUT (
    .clk, .rst_b, .por_event, .bor_event, .ext_reset_event, .pwrsave_retire,
    .pwrsave_operand, .irq_wake_req, .wdt_timeout, .wdt_enabled, .clock_switch_en,
    .current_oscillator_select, .clock_fail_monitor_en, .brownout_en, .ost_done,
    .pll_lock, .osc_running, .reference_ready, .status_we, .status_wdata, .cfg_re,
    .cfg_addr, .peripheral_clock_gate, .status_r, .cfg_rdata_r, .cpu_clk_en_r,
    .periph_clk_en_r, .osc_en_r, .slow_rc_en_r, .monitor_active_r, .brownout_active_r,
    .supply_detect_run_r, .supply_trip_level_r, .irq_vector_r, .clock_fail_trap_r,
    .fast_rc_force_r, .wake_osc_r, .periph_run_r);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Ends with an idle cycle so two writes never touch the strobe in one step
  task automatic wr(input logic [15:0] v);
    status_we = 1'b1;
    status_wdata = v;
    cyc(1);
    status_we = 1'b0;
    cyc(1);
  endtask

  task automatic enter(input logic idle);
    wr(16'h0000);
    pwrsave_operand = idle;
    pwrsave_retire = 1'b1;
    cyc(1);
    pwrsave_retire = 1'b0;
    cyc(2);
  endtask

  // Sources: 0 interrupt, 1 watchdog, 2 external reset, 3 power-on, 4 brown-out
  task automatic wake(input logic idle, input int src);
    int   n;
    logic vec;
    n = 0;
    vec = 1'b0;
    current_oscillator_select = psg_pkg::OSC_EXT_RC;
    enter(idle);
    chk("cpu_en", cpu_clk_en_r, 0);
    chk("per_en", periph_clk_en_r, idle);
    chk("osc_en", osc_en_r, idle);
    chk("mon", monitor_active_r, idle);
    chk("lrc", slow_rc_en_r, 1);
    chk("bor_act", brownout_active_r, 1);
    irq_wake_req = (src == 0);
    wdt_timeout = (src == 1);
    ext_reset_event = (src == 2);
    por_event = (src == 3);
    bor_event = (src == 4);
    while (cpu_clk_en_r !== 1'b1 && n < 60) begin
      cyc(1);
      n++;
      wdt_timeout = 1'b0;
      if (irq_vector_r === 1'b1) vec = 1'b1;
      if (n == 3) {ext_reset_event, por_event, bor_event} = 3'h0;
    end
    {irq_wake_req, ext_reset_event, por_event, bor_event} = 4'h0;
    chk("cpu_back", cpu_clk_en_r, 1);
    if (idle) chk("idle_fast", n <= 6, 1);
    if (!idle && src < 2) chk("sleep_delay", n >= PON, 1);
    chk("flag", status_r[idle ? psg_pkg::POS_IDLE : psg_pkg::POS_SLEEP], src != 3);
    chk("watchdog_timeout_flag", status_r[psg_pkg::POS_WATCHDOG_TIMEOUT_FLAG], src == 1);
    chk("vector", vec, src == 0);
    if (!idle) chk("wosc", wake_osc_r, src > 2 ? psg_pkg::OSC_FAST_RC : psg_pkg::OSC_EXT_RC);
    cyc(3);
  endtask

  // Sleep wake timing per wake clock; keep drives the watchdog and brown-out enables
  task automatic dly(input logic [2:0] osc, input logic keep);
    int n;
    n = 0;
    current_oscillator_select = osc;
    {wdt_enabled, brownout_en} = {keep, keep};
    enter(1'b0);
    chk("d_osc", osc_en_r, osc == psg_pkg::OSC_LP_XTAL);
    chk("d_lrc", slow_rc_en_r, keep);
    chk("d_bor", brownout_active_r, keep);
    irq_wake_req = 1'b1;
    while (cpu_clk_en_r !== 1'b1 && n < 60) begin
      cyc(1);
      n++;
    end
    irq_wake_req = 1'b0;
    if (osc == psg_pkg::OSC_CRYSTAL || osc == psg_pkg::OSC_PLL) begin
      chk("d_slow", n >= PON + SET && n < 60, 1);
    end else begin
      chk("d_fast", n >= PON && n < PON + SET, 1);
    end
    {wdt_enabled, brownout_en} = 2'h3;
    cyc(3);
  endtask

  // Crystal that never starts: trap with monitor on, otherwise stay suspended
  task automatic xtal(input logic mon);
    int   n;
    logic trap;
    n = 0;
    trap = 1'b0;
    clock_fail_monitor_en = mon;
    current_oscillator_select = psg_pkg::OSC_CRYSTAL;
    osc_running = 1'b0;
    enter(1'b0);
    irq_wake_req = 1'b1;
    while (n < 60) begin
      cyc(1);
      n++;
      if (clock_fail_trap_r === 1'b1) trap = 1'b1;
    end
    chk("trap", trap, mon);
    chk("frc", fast_rc_force_r, mon);
    chk("xosc", wake_osc_r, psg_pkg::OSC_CRYSTAL);
    if (!mon) chk("suspend", cpu_clk_en_r, 0);
    osc_running = 1'b1;
    n = 0;
    while (cpu_clk_en_r !== 1'b1 && n < 60) begin
      cyc(1);
      n++;
    end
    if (!mon) chk("resume", cpu_clk_en_r, 1);
    irq_wake_req = 1'b0;
    cyc(3);
  endtask

  initial begin
    #20000;
    err_total++;
    finish_test();
  end

  initial begin
    err_total = 0;
    checked = 0;
    cfg_exp = '{24'h00C100, 24'h00803F, 24'h0087B3, 24'h00310F, 24'h00330F, 24'h000007};
    {rst_b, por_event, bor_event, ext_reset_event, pwrsave_retire, pwrsave_operand} = 6'h00;
    {irq_wake_req, wdt_timeout, status_we, cfg_re, reference_ready, osc_running} = 6'h01;
    {wdt_enabled, clock_switch_en, clock_fail_monitor_en, brownout_en} = 4'hF;
    {ost_done, pll_lock} = 2'h3;
    current_oscillator_select = psg_pkg::OSC_EXT_RC;
    status_wdata = 16'h0000;
    cfg_addr = 24'h000000;
    peripheral_clock_gate = 32'h00000000;
    cyc(5);
    chk("rst_status", status_r, 16'h0003);
    chk("rst_wosc", wake_osc_r, psg_pkg::OSC_FAST_RC);
    chk("rst_run", periph_run_r, 0);
    cyc(1);
    rst_b = 1'b1;
    cyc(1);
    chk("run", periph_run_r, PRES);
    peripheral_clock_gate = 32'h00000020;
    cyc(1);
    chk("gate_off", periph_run_r, PRES & 32'hFFFFFFDF);
    peripheral_clock_gate = 32'h00000000;
    cyc(1);
    chk("gate_on", periph_run_r, PRES);
    wr(16'hDAC0);
    chk("status_wr", status_r, 16'h1A00);
    cyc(2);
    chk("det_run", supply_detect_run_r, 1);
    chk("trip", supply_trip_level_r, 4'hA);
    chk("unsettled", status_r[psg_pkg::POS_SETTLED], 0);
    reference_ready = 1'b1;
    cyc(SET + 8);
    chk("settled", status_r[psg_pkg::POS_SETTLED], 1);
    for (int i = 0; i < 7; i++) begin
      cfg_re = 1'b1;
      cfg_addr = psg_pkg::ADDR_CFG_OSC + 24'(2 * i);
      cyc(1);
      cfg_re = 1'b0;
      cyc(1);
      chk("cfg", cfg_rdata_r, i < 6 ? cfg_exp[i] : 24'h000000);
    end
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 5; s++) begin
        wake(m[0], s);
      end
    end
    dly(psg_pkg::OSC_LP_XTAL, 1'b0);
    dly(psg_pkg::OSC_CRYSTAL, 1'b1);
    dly(psg_pkg::OSC_PLL, 1'b1);
    dly(psg_pkg::OSC_SLOW_RC, 1'b1);
    xtal(1'b0);
    xtal(1'b1);
    rst_b = 1'b0;
    cyc(2);
    chk("rerst", status_r, 16'h0003);
    chk("rerst_frc", fast_rc_force_r, 0);
    rst_b = 1'b1;
    cyc(3);
    finish_test();
  end
endmodule
`default_nettype wire
